// >>> adc_slot_cfg.svh
/*
 * Register offsets, field positions, reset values and widths for the
 * converter slot selection and result bank.
 * Assumes inclusion by bare name from the package and design files.
 */
`ifndef ADC_SLOT_CFG_SVH
`define ADC_SLOT_CFG_SVH

`define SLOT_ADDR_W 6
`define SLOT_DATA_W 24
`define SLOT_SEL_A_ADDR 6'h2D
`define SLOT_SEL_B_ADDR 6'h2E
`define SLOT_RES_01_ADDR 6'h2F
`define SLOT_SEL_A_RESET 24'h000000
`define SLOT_SEL_B_RESET 24'h000000
`define SLOT_RES_RESET 10'h000
`define SLOT_COUNT 8
`define SLOT_CHAN_W 4
`define SLOT_TOUCH_W 2
`define SLOT_RES_W 10
`define SLOT_SEL_B_CHAN_LSB 0
`define SLOT_SEL_B_TOUCH_LSB 8
`define SLOT_SEL_A_SLOTS 6
`define SLOT_EVEN_LSB 2
`define SLOT_ODD_LSB 14

`endif

// >>> adc_slot_checker_assertions.sv
/* Port checker for the slot selection and result bank.
   Assumes it is bound into adc_slot_select_result_bank. */
`timescale 1ns/1ps
`include "adc_slot_cfg.svh"
module adc_slot_checker #(
    parameter int SLOTS = `SLOT_COUNT
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`SLOT_ADDR_W-1:0] reg_addr,
    input wire logic [`SLOT_DATA_W-1:0] reg_wdata,
    input wire logic [`SLOT_DATA_W-1:0] reg_rdata,
    input wire logic seq_start,
    input wire logic seq_continuous,
    input wire logic sequencer_pause,
    input wire logic [2:0] last_slot_sel,
    input wire logic seq_busy,
    input wire logic conv_req,
    input wire logic [2:0] conv_slot,
    input wire logic conv_done,
    input wire logic [`SLOT_RES_W-1:0] conv_data,
    input wire logic [`SLOT_RES_W*SLOTS-1:0] slot_conversion
);
    logic [2:0] slot_q;
    logic filed;
    assign filed = conv_done && conv_req;
    always_ff @(posedge clk)
    begin
        slot_q <= conv_slot;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_result_pack: assert property (reg_rd && reg_addr == `SLOT_RES_01_ADDR |=>
        reg_rdata == {$past(slot_conversion[19:10]), 2'h0, $past(slot_conversion[9:0]), 2'h0})
        else $error("result pair packing wrong");
    a_sel_readback: assert property (reg_wr && reg_addr == `SLOT_SEL_A_ADDR ##1
        reg_rd && !reg_wr && reg_addr == `SLOT_SEL_A_ADDR |=> reg_rdata == $past(reg_wdata, 2))
        else $error("select A readback wrong");
    a_file_slot: assert property (filed |=>
        slot_conversion[10*slot_q+:10] == $past(conv_data)) else $error("result not filed");
    a_start_zero: assert property (!seq_busy && seq_start |=> seq_busy && conv_slot == 3'h0)
        else $error("sequence not started at slot zero");
    a_step_next: assert property (filed && conv_slot != last_slot_sel |=>
        conv_slot == $past(conv_slot) + 3'h1) else $error("slot did not step");
    a_last_idle: assert property (filed && conv_slot == last_slot_sel && !seq_continuous
        && !seq_start |=> !seq_busy) else $error("sequence ran past last slot");
    a_pause_no_req: assert property (sequencer_pause |-> !conv_req)
        else $error("request during pause");
    a_pause_stable: assert property (sequencer_pause [*2] |-> $stable(slot_conversion))
        else $error("results moved during pause");
    a_reset_clear: assert property ($rose(rstn) |-> slot_conversion == '0 && !seq_busy)
        else $error("results not cleared by reset");
    c_full_run: cover property (filed && conv_slot == 3'h7);
    c_pause: cover property (seq_busy && sequencer_pause);
    c_result_read: cover property (reg_rd && reg_addr == `SLOT_RES_01_ADDR);
endmodule : adc_slot_checker
bind adc_slot_select_result_bank adc_slot_checker #(.SLOTS(SLOTS)) chk (.clk(clk), .rstn(rstn),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .seq_start(seq_start), .seq_continuous(seq_continuous),
    .sequencer_pause(sequencer_pause), .last_slot_sel(last_slot_sel), .seq_busy(seq_busy),
    .conv_req(conv_req), .conv_slot(conv_slot), .conv_done(conv_done), .conv_data(conv_data),
    .slot_conversion(slot_conversion));

// >>> adc_slot_pkg.sv
/*
 * Shared types for the converter slot selection and result bank.
 * Assumes adc_slot_cfg.svh is on the include path.
 */
`include "adc_slot_cfg.svh"

package adc_slot_pkg;

    typedef enum logic [1:0] {
        TOUCH_DUMMY_DISCHARGE = 2'h0,
        TOUCH_READ_X = 2'h1,
        TOUCH_READ_Y = 2'h2,
        TOUCH_READ_CONTACT = 2'h3
    } touch_action_e;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'h0,
        SEQ_RUN = 2'h1,
        SEQ_PAUSE = 2'h2
    } seq_state_e;

    typedef logic [`SLOT_CHAN_W-1:0] chan_t;
    typedef logic [`SLOT_RES_W-1:0] result_t;

endpackage : adc_slot_pkg

// >>> adc_slot_select_result_bank.sv
/*
 * Slot selection registers and packed result registers of the converter
 * reading sequencer, with the slot walker that files each result.
 * Assumes a register port driven by the serial control interface on clk,
 * and a converter that answers conv_req with conv_done and conv_data.
 */
`timescale 1ns/1ps
`include "adc_slot_cfg.svh"

module adc_slot_select_result_bank #(
    parameter int SLOTS = `SLOT_COUNT
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`SLOT_ADDR_W-1:0] reg_addr,
    input wire logic [`SLOT_DATA_W-1:0] reg_wdata,
    output logic [`SLOT_DATA_W-1:0] reg_rdata,
    output logic reg_hit,
    input wire logic seq_start,
    input wire logic seq_continuous,
    input wire logic sequencer_pause,
    input wire logic [2:0] last_slot_sel,
    output logic seq_busy,
    output logic conv_req,
    output logic [`SLOT_CHAN_W-1:0] conv_channel,
    output logic [`SLOT_TOUCH_W-1:0] conv_touch_action,
    output logic [2:0] conv_slot,
    input wire logic conv_done,
    input wire logic [`SLOT_RES_W-1:0] conv_data,
    output logic [`SLOT_RES_W*SLOTS-1:0] slot_conversion
);

    logic [`SLOT_DATA_W-1:0] sel_a_q;
    logic [`SLOT_DATA_W-1:0] sel_a_d;
    logic [`SLOT_DATA_W-1:0] sel_b_q;
    logic [`SLOT_DATA_W-1:0] sel_b_d;
    adc_slot_pkg::result_t result_q [SLOTS];
    adc_slot_pkg::result_t result_d [SLOTS];
    logic [`SLOT_DATA_W-1:0] rdata_q;
    logic [`SLOT_DATA_W-1:0] rdata_d;
    logic [2:0] slot;
    logic step_busy;
    logic step_req;

    // channel selector of a slot across both selection registers
    function automatic adc_slot_pkg::chan_t chan_of(input logic [2:0] s,
        input logic [`SLOT_DATA_W-1:0] a, input logic [`SLOT_DATA_W-1:0] b);
        adc_slot_pkg::chan_t c;
        if (s < 3'(`SLOT_SEL_A_SLOTS))
        begin
            c = a[s*`SLOT_CHAN_W +: `SLOT_CHAN_W];
        end
        else
        begin
            c = b[`SLOT_SEL_B_CHAN_LSB + (s - 3'(`SLOT_SEL_A_SLOTS))*`SLOT_CHAN_W
                  +: `SLOT_CHAN_W];
        end
        return c;
    endfunction : chan_of

    // pack an even/odd slot pair into one result word
    function automatic logic [`SLOT_DATA_W-1:0] pack_pair(input adc_slot_pkg::result_t ev,
        input adc_slot_pkg::result_t od);
        logic [`SLOT_DATA_W-1:0] w;
        w = '0; // reserved pairs 1:0 and 13:12 read zero
        w[`SLOT_EVEN_LSB +: `SLOT_RES_W] = ev;
        w[`SLOT_ODD_LSB +: `SLOT_RES_W] = od;
        return w;
    endfunction : pack_pair

    // every mapped offset, for the hit flag
    function automatic logic is_mapped(input logic [`SLOT_ADDR_W-1:0] addr);
        logic hit;
        if (addr == `SLOT_SEL_A_ADDR)
        begin
            hit = 1'b1;
        end
        else if (addr == `SLOT_SEL_B_ADDR)
        begin
            hit = 1'b1;
        end
        else if (addr == `SLOT_RES_01_ADDR)
        begin
            hit = 1'b1;
        end
        else
        begin
            hit = 1'b0;
        end
        return hit;
    endfunction : is_mapped

    // touch action field of a slot; the code goes out unchanged
    function automatic adc_slot_pkg::touch_action_e touch_of(input logic [2:0] s,
        input logic [`SLOT_DATA_W-1:0] b);
        return adc_slot_pkg::touch_action_e'(b[`SLOT_SEL_B_TOUCH_LSB + s*`SLOT_TOUCH_W
            +: `SLOT_TOUCH_W]);
    endfunction : touch_of

    slot_stepper #(
        .SLOTS(SLOTS)
    ) u_stepper (
        .clk(clk),
        .rstn(rstn),
        .start(seq_start),
        .continuous(seq_continuous),
        .pause(sequencer_pause),
        .last_slot_sel(last_slot_sel),
        .conv_done(conv_done && step_req),
        .busy(step_busy),
        .conv_req(step_req),
        .slot(slot)
    );

    // selection words are read live by the walker, so a write
    // mid-sequence takes effect on the next cycle, even for the slot in conversion
    always_comb
    begin
        sel_a_d = sel_a_q;
        sel_b_d = sel_b_q;
        if (reg_wr)
        begin
            if (reg_addr == `SLOT_SEL_A_ADDR)
            begin
                sel_a_d = reg_wdata;
            end
            else if (reg_addr == `SLOT_SEL_B_ADDR)
            begin
                sel_b_d = reg_wdata;
            end
        end
    end

    always_comb
    begin
        for (int i = 0; i < SLOTS; i++)
        begin
            result_d[i] = result_q[i];
        end
        // a paused sequencer never files, so reads see a stable pair
        if (conv_done && step_req)
        begin
            result_d[slot] = conv_data;
        end
    end

    // held until the next read so a slow host sees one stable word
    always_comb
    begin
        rdata_d = rdata_q;
        if (reg_rd)
        begin
            if (reg_addr == `SLOT_SEL_A_ADDR)
            begin
                rdata_d = sel_a_q;
            end
            else if (reg_addr == `SLOT_SEL_B_ADDR)
            begin
                rdata_d = sel_b_q;
            end
            else if (reg_addr == `SLOT_RES_01_ADDR)
            begin
                rdata_d = pack_pair(result_q[0], result_q[1]);
            end
            else
            begin
                rdata_d = '0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sel_a_q <= `SLOT_SEL_A_RESET;
            sel_b_q <= `SLOT_SEL_B_RESET;
            rdata_q <= '0;
            for (int i = 0; i < SLOTS; i++)
            begin
                result_q[i] <= `SLOT_RES_RESET;
            end
        end
        else
        begin
            sel_a_q <= sel_a_d;
            sel_b_q <= sel_b_d;
            rdata_q <= rdata_d;
            for (int i = 0; i < SLOTS; i++)
            begin
                result_q[i] <= result_d[i];
            end
        end
    end

    always_comb
    begin
        for (int i = 0; i < SLOTS; i++)
        begin
            slot_conversion[i*`SLOT_RES_W +: `SLOT_RES_W] = result_q[i];
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_hit = is_mapped(reg_addr);
    assign seq_busy = step_busy;
    assign conv_req = step_req;
    assign conv_slot = slot;
    assign conv_channel = chan_of(slot, sel_a_q, sel_b_q);
    // 00 dummy discharge, 01 X plate, 10 Y plate, 11 contact
    assign conv_touch_action = touch_of(slot, sel_b_q);

endmodule : adc_slot_select_result_bank

// >>> conv_model.sv
/* Converter model: answers each request after lat idle cycles.
   Assumes requests and answers on the same clock as the bank. */
`timescale 1ns/1ps
module conv_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic conv_req,
    input wire logic [3:0] conv_channel,
    input wire logic [1:0] conv_touch_action,
    input wire logic [2:0] conv_slot,
    input wire logic [3:0] lat,
    output logic conv_done,
    output logic [9:0] conv_data
);
    logic [3:0] cnt;
    // data echoes the slot settings so the bench can tell which selector was used
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt <= 4'h0;
            conv_done <= 1'b0;
            conv_data <= 10'h000;
        end
        else if (conv_done)
        begin
            conv_done <= 1'b0;
            cnt <= 4'h0;
            conv_data <= ~conv_data;
        end
        else if (conv_req && cnt >= lat)
        begin
            conv_done <= 1'b1;
            conv_data <= {conv_channel, conv_touch_action, 1'b0, conv_slot};
        end
        else
            cnt <= conv_req ? cnt + 4'h1 : 4'h0;
    end
endmodule : conv_model

// >>> slot_stepper.sv
/*
 * Slot walker: steps a slot index from zero up to and including the last
 * slot, pausing while the pause control is high.
 * Assumes start, pause and conv_done come from logic on the same clock.
 */
`timescale 1ns/1ps
`include "adc_slot_cfg.svh"

module slot_stepper #(
    parameter int SLOTS = `SLOT_COUNT
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic start,
    input wire logic continuous,
    input wire logic pause,
    input wire logic [2:0] last_slot_sel,
    input wire logic conv_done,
    output logic busy,
    output logic conv_req,
    output logic [2:0] slot
);

    adc_slot_pkg::seq_state_e state_q;
    adc_slot_pkg::seq_state_e state_d;
    logic [2:0] slot_q;
    logic [2:0] slot_d;

    always_comb
    begin
        state_d = state_q;
        slot_d = slot_q;
        case (state_q)
            adc_slot_pkg::SEQ_IDLE:
            begin
                if (start)
                begin
                    slot_d = 3'h0;
                    state_d = pause ? adc_slot_pkg::SEQ_PAUSE : adc_slot_pkg::SEQ_RUN;
                end
            end
            adc_slot_pkg::SEQ_RUN:
            begin
                if (conv_done)
                begin
                    if (slot_q == last_slot_sel)
                    begin
                        slot_d = 3'h0;
                        if (!continuous)
                        begin
                            state_d = adc_slot_pkg::SEQ_IDLE;
                        end
                    end
                    else
                    begin
                        slot_d = slot_q + 3'h1;
                    end
                    if (pause && state_d != adc_slot_pkg::SEQ_IDLE)
                    begin
                        state_d = adc_slot_pkg::SEQ_PAUSE;
                    end
                end
                else if (pause)
                begin
                    state_d = adc_slot_pkg::SEQ_PAUSE;
                end
            end
            adc_slot_pkg::SEQ_PAUSE:
            begin
                if (!pause)
                begin
                    state_d = adc_slot_pkg::SEQ_RUN;
                end
            end
            default:
            begin
                state_d = adc_slot_pkg::SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= adc_slot_pkg::SEQ_IDLE;
            slot_q <= 3'h0;
        end
        else
        begin
            state_q <= state_d;
            slot_q <= slot_d;
        end
    end

    // a pause aborts the outstanding request so results stay frozen
    assign conv_req = (state_q == adc_slot_pkg::SEQ_RUN) && !pause;
    assign busy = (state_q != adc_slot_pkg::SEQ_IDLE);
    assign slot = slot_q;

endmodule : slot_stepper

// >>> testbench.sv
/* Self-checking bench for the slot bank with a converter model.
   Assumes the design, checker and converter model are compiled first. */
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
    $display("BAD t=%0t got %h exp %h", $time, (g), (e)); end end
module testbench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic [23:0] reg_wdata = 24'h000000;
    logic [23:0] reg_rdata;
    logic reg_hit;
    logic seq_start = 1'b0;
    logic seq_continuous = 1'b0;
    logic sequencer_pause = 1'b0;
    logic [2:0] last_slot_sel = 3'h0;
    logic [3:0] lat = 4'h0;
    logic seq_busy, conv_req, conv_done;
    logic [3:0] conv_channel;
    logic [1:0] conv_touch_action;
    logic [2:0] conv_slot;
    logic [9:0] conv_data;
    logic [79:0] slot_conversion;
    logic [79:0] snap;
    int failures = 0;
    int checks = 0;
    localparam logic [23:0] SEL_A1 = 24'h9A5C31;
    localparam logic [23:0] SEL_A2 = 24'h0B6D7E;
    localparam logic [23:0] SEL_B1 = 24'hE4E4F2;
    always #2 clk = ~clk;
    adc_slot_select_result_bank dut (.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
        .seq_start(seq_start), .seq_continuous(seq_continuous),
        .sequencer_pause(sequencer_pause), .last_slot_sel(last_slot_sel), .seq_busy(seq_busy),
        .conv_req(conv_req), .conv_channel(conv_channel), .conv_touch_action(conv_touch_action),
        .conv_slot(conv_slot), .conv_done(conv_done), .conv_data(conv_data),
        .slot_conversion(slot_conversion));
    conv_model conv (.clk(clk), .rstn(rstn), .conv_req(conv_req), .conv_channel(conv_channel),
        .conv_touch_action(conv_touch_action), .conv_slot(conv_slot), .lat(lat),
        .conv_done(conv_done), .conv_data(conv_data));
    function automatic logic [9:0] ex(input int s, input logic [23:0] a, input logic [23:0] b);
        logic [3:0] ch;
        ch = (s < 6) ? a[4*s+:4] : b[4*(s-6)+:4];
        return {ch, b[8+2*s+:2], 1'b0, s[2:0]};
    endfunction : ex
    task automatic conclude;
        $display("failures=%0d checks=%0d", failures, checks);
        if (failures == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude
    task automatic rd(input logic [5:0] a, output logic [23:0] d);
        @(posedge clk); reg_rd <= 1'b1; reg_addr <= a;
        @(posedge clk); reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    // read lands on the cycle right after the write
    task automatic wr_rd(input logic [5:0] a, input logic [23:0] w, output logic [23:0] d);
        @(posedge clk); reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= w;
        @(posedge clk); reg_wr <= 1'b0; reg_rd <= 1'b1;
        @(posedge clk); reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : wr_rd
    task automatic go(input logic [2:0] last, input logic [3:0] l);
        @(posedge clk); seq_start <= 1'b1; last_slot_sel <= last; lat <= l;
        @(posedge clk); seq_start <= 1'b0;
    endtask : go
    task automatic wait_idle;
        int n;
        for (n = 0; n < 200; n++)
        begin
            @(posedge clk);
            #1;
            if (seq_busy === 1'b0) break;
        end
        if (n == 200)
        begin
            failures++;
            conclude();
        end
    endtask : wait_idle
    task automatic t_regs;
        logic [23:0] v;
        rd(6'h2D, v); `CHK(v, 24'h000000)
        `CHK(reg_hit, 1'b1)
        rd(6'h2E, v); `CHK(v, 24'h000000)
        wr_rd(6'h2D, SEL_A1, v); `CHK(v, SEL_A1)
        wr_rd(6'h2E, SEL_B1, v); `CHK(v, SEL_B1)
        rd(6'h30, v); `CHK(v, 24'h000000)
        `CHK(reg_hit, 1'b0)
        wr_rd(6'h2F, 24'hFFFFFF, v); `CHK(v, 24'h000000)
    endtask : t_regs
    task automatic t_full;
        logic [23:0] v;
        go(3'h7, 4'h0);
        wait_idle();
        for (int s = 0; s < 8; s++) `CHK(slot_conversion[10*s+:10], ex(s, SEL_A1, SEL_B1))
        rd(6'h2F, v);
        `CHK(v, {ex(1, SEL_A1, SEL_B1), 2'h0, ex(0, SEL_A1, SEL_B1), 2'h0})
    endtask : t_full
    task automatic t_partial;
        logic [23:0] v;
        wr_rd(6'h2D, SEL_A2, v);
        `CHK(v, SEL_A2)
        go(3'h2, 4'h3);
        wait_idle();
        for (int s = 0; s < 8; s++)
            `CHK(slot_conversion[10*s+:10], ex(s, s < 3 ? SEL_A2 : SEL_A1, SEL_B1))
    endtask : t_partial
    task automatic t_pause_reset;
        logic [23:0] v;
        seq_continuous <= 1'b1;
        wr_rd(6'h2D, SEL_A1, v);
        `CHK(v, SEL_A1)
        go(3'h7, 4'h2);
        repeat (5) @(posedge clk);
        sequencer_pause <= 1'b1;
        repeat (2) @(posedge clk);
        #1 snap = slot_conversion;
        repeat (10) @(posedge clk);
        #1 `CHK(slot_conversion, snap)
        `CHK(conv_req, 1'b0)
        @(posedge clk); sequencer_pause <= 1'b0;
        repeat (20) @(posedge clk);
        `CHK(slot_conversion[19:10], ex(1, SEL_A1, SEL_B1))
        rstn <= 1'b0;
        #1 `CHK(slot_conversion, 80'h0)
        @(posedge clk); rstn <= 1'b1; seq_continuous <= 1'b0;
        rd(6'h2E, v); `CHK(v, 24'h000000)
    endtask : t_pause_reset
    initial
    begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_full();
        t_partial();
        t_pause_reset();
        conclude();
    end
endmodule : testbench
